// ===== common/alu_core_pkg.sv
// Package with opcodes, flag layout, register map and reset values for the move/shift datapath.
// Operation
// RULE1 - Signed-range flag set on signed overflow
// RULE2 - Result-null flag set when result zero
// RULE3 - Wrap-out flag takes carry or borrow
// RULE4 - Low-half-out flag takes nibble carry
// RULE5 - Bit forms reach addresses 0 to 0x3F
// RULE6 - Loads update null flag; stores keep flags; here the immediate load (OP_MOV_A_I) keeps flags
// RULE7 - Timer word load copies count to memory
// RULE8 - Timer word store loads count from memory
// RULE9 - Indirect move via pointer, two cycles, no flags; here the read takes five cycles after the command and the write three
// RULE10 - Exchange swaps work register and memory
// RULE11 - Save status pushes flags, work, pointer+2
// RULE12 - Restore status pops after pointer-2, all flags
// RULE13 - Addition updates all four flags
// RULE14 - Sum-with-carry forms add wrap-out flag
// RULE15 - Negate-then-sum stores into negated operand
// RULE16 - Subtraction adds complement of subtrahend
// RULE17 - Difference-with-borrow forms subtract wrap-out flag
// RULE18 - Memory increment and decrement update flags
// RULE19 - Clear writes zero, flags unchanged
// RULE20 - Right shifts: bit0 to wrap-out flag
// RULE21 - Left shifts: bit7 to wrap-out flag
// RULE22 - Nibble swap of work register, no flags
// RULE23 - Eight-bit datapath, one cycle except indirect; here a memory read adds one cycle, timer and stack forms more
package alu_core_pkg;

  typedef enum logic [5:0] {
    OP_NOP        = 6'h00,
    OP_MOV_A_I    = 6'h01,
    OP_MOV_M_A    = 6'h02,
    OP_MOV_A_M    = 6'h03,
    OP_MOV_A_IO   = 6'h04,
    OP_MOV_IO_A   = 6'h05,
    OP_TWL        = 6'h06,
    OP_TWS        = 6'h07,
    OP_IDX_RD     = 6'h08,
    OP_IDX_WR     = 6'h09,
    OP_XCH        = 6'h0A,
    OP_PUSHAF     = 6'h0B,
    OP_POPAF      = 6'h0C,
    OP_ADD_A_I    = 6'h0D,
    OP_ADD_A_M    = 6'h0E,
    OP_ADD_M_A    = 6'h0F,
    OP_ADDC_A_M   = 6'h10,
    OP_ADDC_M_A   = 6'h11,
    OP_ADDC_A     = 6'h12,
    OP_ADDC_M     = 6'h13,
    OP_NADD_A_M   = 6'h14,
    OP_NADD_M_A   = 6'h15,
    OP_SUB_A_I    = 6'h16,
    OP_SUB_A_M    = 6'h17,
    OP_SUB_M_A    = 6'h18,
    OP_SUBC_A_M   = 6'h19,
    OP_SUBC_M_A   = 6'h1A,
    OP_SUBC_A     = 6'h1B,
    OP_SUBC_M     = 6'h1C,
    OP_INC_M      = 6'h1D,
    OP_DEC_M      = 6'h1E,
    OP_CLEAR_M    = 6'h1F,
    OP_SR_A       = 6'h20,
    OP_SRC_A      = 6'h21,
    OP_SR_M       = 6'h22,
    OP_SRC_M      = 6'h23,
    OP_SL_A       = 6'h24,
    OP_SLC_A      = 6'h25,
    OP_SL_M       = 6'h26,
    OP_SLC_M      = 6'h27,
    OP_SWAP_A     = 6'h28
  } op_e;

  // Flag register bit positions.
  localparam int FLAG_Z  = 0;
  localparam int FLAG_C  = 1;
  localparam int FLAG_AC = 2;
  localparam int FLAG_OV = 3;

  localparam logic [7:0] WORK_RESET = 8'h00;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] BIT_ADDR_MAX = 8'h3F;
  localparam logic [7:0] PTR_STEP = 8'h02;

  // Wishbone register map (byte addresses).
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_WORK   = 8'h04;
  localparam logic [7:0] REG_FLAGS  = 8'h08;
  localparam logic [7:0] REG_PTR    = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;

  // Command register fields.
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_IMM_LSB  = 16;
  localparam int CMD_BIT_POS  = 24;

  typedef struct packed {
    logic [5:0] op;
    logic [7:0] addr;
    logic [7:0] imm;
    logic       bit_form;
  } cmd_s;

  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mem_req_s;

endpackage

// ===== rtl/alu_move_shift_core.sv
// Execution datapath for move, arithmetic and shift instructions with a Wishbone slave.
//
// Our own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module alu_move_shift_core
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [7:0]  mem_rdata_i,
  input  wire logic [7:0]  io_rdata_i,
  input  wire logic [15:0] timer_count_i,
  output logic             mem_we_o,
  output logic      [7:0]  mem_addr_o,
  output logic      [7:0]  mem_wdata_o,
  output logic             io_we_o,
  output logic      [7:0]  io_addr_o,
  output logic      [7:0]  io_wdata_o,
  output logic             timer_load_o,
  output logic      [15:0] timer_value_o
);

  // Multi-cycle sequencer: memory is read one cycle after the address is issued.
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RD    = 3'b001,
    ST_EXEC  = 3'b010,
    ST_RD2   = 3'b011,
    ST_PTRHI = 3'b100,
    ST_IDX   = 3'b101,
    ST_WR2   = 3'b110
  } st_e;

  typedef alu_core_pkg::op_e op_e;

  st_e         state_q;
  alu_core_pkg::cmd_s cmd_q;
  logic [7:0]  work_q;
  logic [3:0]  flags_q;
  logic [7:0]  ptr_q;
  logic [7:0]  lo_q;
  logic        bad_addr_q;
  logic [7:0]  done_cnt_q;
  logic        wb_req;
  logic        start;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign start = wb_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == alu_core_pkg::REG_CMD)
                 && (state_q == ST_IDLE);

  // Bus slave: a command write stalls ack until the sequencer is idle again.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_req && !(wb_we_i && wb_adr_i == alu_core_pkg::REG_CMD
                              && state_q != ST_IDLE);
      case (wb_adr_i)
        alu_core_pkg::REG_WORK:   wb_dat_o <= {24'h00_0000, work_q};
        alu_core_pkg::REG_FLAGS:  wb_dat_o <= {28'h000_0000, flags_q};
        alu_core_pkg::REG_PTR:    wb_dat_o <= {24'h00_0000, ptr_q};
        alu_core_pkg::REG_STATUS:
          wb_dat_o <= {15'h0000, bad_addr_q, done_cnt_q, 5'h00, state_q};
        default:                  wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Arithmetic: x + y + cin; sub selects complement and inverts carry into borrow.
  logic [7:0] ax;
  logic [7:0] ay;
  logic       acin;
  logic       asub;
  logic [8:0] asum;
  logic [4:0] anib;
  logic [7:0] ares;
  logic [3:0] aflags;
  logic [7:0] mval;
  logic [7:0] yraw;

  always_comb
  begin
    ax = work_q;
    yraw = mval;
    acin = 1'b0;
    asub = 1'b0;
    case (op_e'(cmd_q.op))
      alu_core_pkg::OP_ADD_A_I:  yraw = cmd_q.imm; // RULE13
      alu_core_pkg::OP_ADD_A_M,
      alu_core_pkg::OP_ADD_M_A:  yraw = mval; // RULE13
      alu_core_pkg::OP_ADDC_A_M,
      alu_core_pkg::OP_ADDC_M_A: acin = flags_q[alu_core_pkg::FLAG_C]; // RULE14
      alu_core_pkg::OP_ADDC_A:
      begin
        yraw = 8'h00;
        acin = flags_q[alu_core_pkg::FLAG_C]; // RULE14
      end
      alu_core_pkg::OP_ADDC_M:
      begin
        ax = mval;
        yraw = 8'h00;
        acin = flags_q[alu_core_pkg::FLAG_C]; // RULE14
      end
      alu_core_pkg::OP_NADD_A_M:
      begin
        ax = mval;
        yraw = work_q;
        asub = 1'b1; // RULE15
      end
      alu_core_pkg::OP_NADD_M_A: asub = 1'b1; // RULE15
      alu_core_pkg::OP_SUB_A_I:
      begin
        yraw = cmd_q.imm;
        asub = 1'b1; // RULE16
      end
      alu_core_pkg::OP_SUB_A_M:  asub = 1'b1; // RULE16
      alu_core_pkg::OP_SUB_M_A:
      begin
        ax = mval;
        yraw = work_q;
        asub = 1'b1; // RULE16
      end
      alu_core_pkg::OP_SUBC_A_M:
      begin
        asub = 1'b1;
        acin = flags_q[alu_core_pkg::FLAG_C]; // RULE17
      end
      alu_core_pkg::OP_SUBC_M_A:
      begin
        ax = mval;
        yraw = work_q;
        asub = 1'b1;
        acin = flags_q[alu_core_pkg::FLAG_C]; // RULE17
      end
      alu_core_pkg::OP_SUBC_A:
      begin
        yraw = 8'h00;
        asub = 1'b1;
        acin = flags_q[alu_core_pkg::FLAG_C]; // RULE17
      end
      alu_core_pkg::OP_SUBC_M:
      begin
        ax = mval;
        yraw = 8'h00;
        asub = 1'b1;
        acin = flags_q[alu_core_pkg::FLAG_C]; // RULE17
      end
      alu_core_pkg::OP_INC_M:
      begin
        ax = mval;
        yraw = 8'h00;
        acin = 1'b1; // RULE18
      end
      alu_core_pkg::OP_DEC_M:
      begin
        ax = mval;
        yraw = 8'h01;
        asub = 1'b1; // RULE18
      end
      default: yraw = mval;
    endcase
    // Subtraction x - y - b is x + ~y + !b; carries are inverted to become borrows.
    ay = asub ? ~yraw : yraw;
    asum = {1'b0, ax} + {1'b0, ay} + {8'h00, asub ^ acin};
    anib = {1'b0, ax[3:0]} + {1'b0, ay[3:0]} + {4'h0, asub ^ acin};
    ares = asum[7:0];
    aflags[alu_core_pkg::FLAG_Z]  = (ares == 8'h00); // RULE2
    aflags[alu_core_pkg::FLAG_C]  = asum[8] ^ asub; // RULE3
    aflags[alu_core_pkg::FLAG_AC] = anib[4] ^ asub; // RULE4
    aflags[alu_core_pkg::FLAG_OV] = (ax[7] == ay[7]) && (ares[7] != ax[7]); // RULE1
  end

  assign mval = mem_rdata_i;

  // Whether an operation needs a memory read before it executes.
  function automatic logic needs_read(input logic [5:0] op);
    case (op_e'(op))
      alu_core_pkg::OP_NOP, alu_core_pkg::OP_MOV_A_I, alu_core_pkg::OP_MOV_M_A,
      alu_core_pkg::OP_MOV_A_IO, alu_core_pkg::OP_MOV_IO_A, alu_core_pkg::OP_TWL,
      alu_core_pkg::OP_PUSHAF, alu_core_pkg::OP_ADD_A_I, alu_core_pkg::OP_ADDC_A,
      alu_core_pkg::OP_SUB_A_I, alu_core_pkg::OP_SUBC_A, alu_core_pkg::OP_CLEAR_M,
      alu_core_pkg::OP_SR_A, alu_core_pkg::OP_SRC_A, alu_core_pkg::OP_SL_A,
      alu_core_pkg::OP_SLC_A, alu_core_pkg::OP_SWAP_A: needs_read = 1'b0;
      default: needs_read = 1'b1;
    endcase
  endfunction

  logic [7:0] shv;
  logic       shc;
  logic       fc;

  // Shifter on the work register or the memory byte.
  always_comb
  begin
    fc = flags_q[alu_core_pkg::FLAG_C];
    shv = work_q;
    shc = fc;
    case (op_e'(cmd_q.op))
      alu_core_pkg::OP_SR_A:  {shv, shc} = {1'b0, work_q}; // RULE20
      alu_core_pkg::OP_SRC_A: {shv, shc} = {fc, work_q}; // RULE20
      alu_core_pkg::OP_SR_M:  {shv, shc} = {1'b0, mval}; // RULE20
      alu_core_pkg::OP_SRC_M: {shv, shc} = {fc, mval}; // RULE20
      alu_core_pkg::OP_SL_A:  {shc, shv} = {work_q, 1'b0}; // RULE21
      alu_core_pkg::OP_SLC_A: {shc, shv} = {work_q, fc}; // RULE21
      alu_core_pkg::OP_SL_M:  {shc, shv} = {mval, 1'b0}; // RULE21
      alu_core_pkg::OP_SLC_M: {shc, shv} = {mval, fc}; // RULE21
      default:                shv = work_q;
    endcase
  end

  // Sequencer, memory port and architectural state.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_IDLE;
      cmd_q <= '0;
      work_q <= alu_core_pkg::WORK_RESET;
      flags_q <= alu_core_pkg::FLAGS_RESET;
      ptr_q <= alu_core_pkg::PTR_RESET;
      lo_q <= 8'h00;
      bad_addr_q <= 1'b0;
      done_cnt_q <= 8'h00;
      mem_we_o <= 1'b0;
      mem_addr_o <= 8'h00;
      mem_wdata_o <= 8'h00;
      io_we_o <= 1'b0;
      io_addr_o <= 8'h00;
      io_wdata_o <= 8'h00;
      timer_load_o <= 1'b0;
      timer_value_o <= 16'h0000;
    end
    else
    begin
      mem_we_o <= 1'b0;
      io_we_o <= 1'b0;
      timer_load_o <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (wb_req && wb_we_i && wb_adr_i == alu_core_pkg::REG_WORK && wb_sel_i[0])
            work_q <= wb_dat_i[7:0];
          if (wb_req && wb_we_i && wb_adr_i == alu_core_pkg::REG_FLAGS && wb_sel_i[0])
            flags_q <= wb_dat_i[3:0];
          if (wb_req && wb_we_i && wb_adr_i == alu_core_pkg::REG_PTR && wb_sel_i[0])
            ptr_q <= wb_dat_i[7:0];
          if (start)
          begin
            cmd_q.op <= wb_dat_i[alu_core_pkg::CMD_OP_LSB +: 6];
            cmd_q.addr <= wb_dat_i[alu_core_pkg::CMD_ADDR_LSB +: 8];
            cmd_q.imm <= wb_dat_i[alu_core_pkg::CMD_IMM_LSB +: 8];
            cmd_q.bit_form <= wb_dat_i[alu_core_pkg::CMD_BIT_POS];
            // Bit forms beyond the low 64 bytes are refused and flagged.
            if (wb_dat_i[alu_core_pkg::CMD_BIT_POS]
                && wb_dat_i[alu_core_pkg::CMD_ADDR_LSB +: 8] > alu_core_pkg::BIT_ADDR_MAX)
              bad_addr_q <= 1'b1; // RULE5
            else
            begin
              bad_addr_q <= 1'b0;
              mem_addr_o <= wb_dat_i[alu_core_pkg::CMD_ADDR_LSB +: 8];
              io_addr_o <= wb_dat_i[alu_core_pkg::CMD_ADDR_LSB +: 8];
              if (op_e'(wb_dat_i[5:0]) == alu_core_pkg::OP_PUSHAF
                  || op_e'(wb_dat_i[5:0]) == alu_core_pkg::OP_POPAF)
                mem_addr_o <= ptr_q;
              if (op_e'(wb_dat_i[5:0]) == alu_core_pkg::OP_POPAF)
              begin
                ptr_q <= ptr_q - alu_core_pkg::PTR_STEP; // RULE12
                mem_addr_o <= ptr_q - alu_core_pkg::PTR_STEP;
              end
              state_q <= needs_read(wb_dat_i[5:0]) ? ST_RD : ST_EXEC; // RULE23
            end
          end
        end
        ST_RD:
          state_q <= ST_EXEC;
        ST_EXEC:
        begin
          state_q <= ST_IDLE;
          done_cnt_q <= done_cnt_q + 8'h01;
          case (op_e'(cmd_q.op))
            alu_core_pkg::OP_MOV_A_I: work_q <= cmd_q.imm; // RULE6
            alu_core_pkg::OP_MOV_M_A:
            begin
              mem_we_o <= 1'b1;
              mem_wdata_o <= work_q; // RULE6
            end
            alu_core_pkg::OP_MOV_A_M:
            begin
              work_q <= mval;
              flags_q[alu_core_pkg::FLAG_Z] <= (mval == 8'h00); // RULE6
            end
            alu_core_pkg::OP_MOV_A_IO:
            begin
              work_q <= io_rdata_i;
              flags_q[alu_core_pkg::FLAG_Z] <= (io_rdata_i == 8'h00); // RULE6
            end
            alu_core_pkg::OP_MOV_IO_A:
            begin
              io_we_o <= 1'b1;
              io_wdata_o <= work_q;
            end
            alu_core_pkg::OP_TWL:
            begin
              mem_we_o <= 1'b1;
              mem_wdata_o <= timer_count_i[7:0]; // RULE7
              lo_q <= timer_count_i[15:8];
              state_q <= ST_WR2;
            end
            alu_core_pkg::OP_TWS:
            begin
              lo_q <= mval;
              mem_addr_o <= cmd_q.addr + 8'h01;
              state_q <= ST_RD2;
            end
            alu_core_pkg::OP_IDX_RD, alu_core_pkg::OP_IDX_WR:
            begin
              lo_q <= mval;
              mem_addr_o <= cmd_q.addr + 8'h01;
              state_q <= ST_PTRHI;
            end
            alu_core_pkg::OP_XCH:
            begin
              work_q <= mval;
              mem_we_o <= 1'b1;
              mem_wdata_o <= work_q; // RULE10
            end
            alu_core_pkg::OP_PUSHAF:
            begin
              mem_we_o <= 1'b1;
              mem_wdata_o <= work_q;
              lo_q <= {4'h0, flags_q};
              state_q <= ST_WR2; // RULE11
            end
            alu_core_pkg::OP_POPAF:
            begin
              work_q <= mval;
              mem_addr_o <= mem_addr_o + 8'h01;
              state_q <= ST_RD2; // RULE12
            end
            alu_core_pkg::OP_ADD_A_I, alu_core_pkg::OP_ADD_A_M, alu_core_pkg::OP_ADDC_A_M,
            alu_core_pkg::OP_ADDC_A, alu_core_pkg::OP_NADD_A_M, alu_core_pkg::OP_SUB_A_I,
            alu_core_pkg::OP_SUB_A_M, alu_core_pkg::OP_SUBC_A_M, alu_core_pkg::OP_SUBC_A:
            begin
              work_q <= ares;
              flags_q <= aflags; // RULE13
            end
            alu_core_pkg::OP_ADD_M_A, alu_core_pkg::OP_ADDC_M_A, alu_core_pkg::OP_ADDC_M,
            alu_core_pkg::OP_NADD_M_A, alu_core_pkg::OP_SUB_M_A, alu_core_pkg::OP_SUBC_M_A,
            alu_core_pkg::OP_SUBC_M, alu_core_pkg::OP_INC_M, alu_core_pkg::OP_DEC_M:
            begin
              mem_we_o <= 1'b1;
              mem_wdata_o <= ares;
              flags_q <= aflags; // RULE18
            end
            alu_core_pkg::OP_CLEAR_M:
            begin
              mem_we_o <= 1'b1;
              mem_wdata_o <= 8'h00; // RULE19
            end
            alu_core_pkg::OP_SR_A, alu_core_pkg::OP_SRC_A, alu_core_pkg::OP_SL_A,
            alu_core_pkg::OP_SLC_A:
            begin
              work_q <= shv;
              flags_q[alu_core_pkg::FLAG_C] <= shc; // RULE20 RULE21
            end
            alu_core_pkg::OP_SR_M, alu_core_pkg::OP_SRC_M, alu_core_pkg::OP_SL_M,
            alu_core_pkg::OP_SLC_M:
            begin
              mem_we_o <= 1'b1;
              mem_wdata_o <= shv;
              flags_q[alu_core_pkg::FLAG_C] <= shc; // RULE20 RULE21
            end
            alu_core_pkg::OP_SWAP_A: work_q <= {work_q[3:0], work_q[7:4]}; // RULE22
            default: work_q <= work_q;
          endcase
        end
        ST_RD2:
          state_q <= ST_WR2;
        ST_WR2:
        begin
          state_q <= ST_IDLE;
          case (op_e'(cmd_q.op))
            alu_core_pkg::OP_TWL:
            begin
              mem_we_o <= 1'b1;
              mem_addr_o <= cmd_q.addr + 8'h01;
              mem_wdata_o <= lo_q; // RULE7
            end
            alu_core_pkg::OP_TWS:
            begin
              timer_load_o <= 1'b1;
              timer_value_o <= {mval, lo_q}; // RULE8
            end
            alu_core_pkg::OP_PUSHAF:
            begin
              mem_we_o <= 1'b1;
              mem_addr_o <= ptr_q + 8'h01;
              mem_wdata_o <= lo_q;
              ptr_q <= ptr_q + alu_core_pkg::PTR_STEP; // RULE11
            end
            alu_core_pkg::OP_POPAF: flags_q <= mval[3:0]; // RULE12
            default: state_q <= ST_IDLE;
          endcase
        end
        ST_PTRHI:
        begin
          // The pointer's high byte must be zero; the low byte is the target address.
          state_q <= ST_IDX;
          mem_addr_o <= lo_q; // RULE9
          bad_addr_q <= (mval != 8'h00);
          if (op_e'(cmd_q.op) == alu_core_pkg::OP_IDX_WR)
          begin
            mem_we_o <= 1'b1;
            mem_wdata_o <= work_q; // RULE9
            state_q <= ST_IDLE;
          end
        end
        ST_IDX:
          state_q <= ST_WR2;
        default:
          state_q <= ST_IDLE;
      endcase
      if (state_q == ST_WR2 && op_e'(cmd_q.op) == alu_core_pkg::OP_IDX_RD)
        work_q <= mval; // RULE9
    end
  end

  a_null_flag: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
    state_q == ST_EXEC && op_e'(cmd_q.op) == alu_core_pkg::OP_ADD_A_M
    |=> flags_q[alu_core_pkg::FLAG_Z] == (work_q == 8'h00))
    else $error("null flag does not match result");
  a_swap_no_flags: assert property (@(posedge clk_i) disable iff (rst_i) // RULE22
    state_q == ST_EXEC && op_e'(cmd_q.op) == alu_core_pkg::OP_SWAP_A
    |=> $stable(flags_q) && work_q == {$past(work_q[3:0]), $past(work_q[7:4])})
    else $error("swap changed flags or value");
  a_clear_zero: assert property (@(posedge clk_i) disable iff (rst_i) // RULE19
    state_q == ST_EXEC && op_e'(cmd_q.op) == alu_core_pkg::OP_CLEAR_M
    |=> mem_we_o && mem_wdata_o == 8'h00 && $stable(flags_q))
    else $error("clear did not write zero");
  a_bit_range: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
    start && wb_dat_i[alu_core_pkg::CMD_BIT_POS] && wb_dat_i[15:8] > 8'h3F
    |=> state_q == ST_IDLE && bad_addr_q)
    else $error("bit form above 0x3F accepted");
  a_push_step: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
    state_q == ST_WR2 && op_e'(cmd_q.op) == alu_core_pkg::OP_PUSHAF
    |=> ptr_q == $past(ptr_q) + 8'h02)
    else $error("push pointer not advanced by two");
  a_store_timer: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
    start && wb_dat_i[5:0] == 6'h07 && !wb_dat_i[24] |-> ##5 timer_load_o)
    else $error("timer store did not load");
  a_shift_right: assert property (@(posedge clk_i) disable iff (rst_i) // RULE20
    state_q == ST_EXEC && op_e'(cmd_q.op) == alu_core_pkg::OP_SR_A
    |=> flags_q[alu_core_pkg::FLAG_C] == $past(work_q[0]) && !work_q[7])
    else $error("right shift wrong");
  a_move_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i) // RULE23
    start && wb_dat_i[5:0] == 6'h01 && !wb_dat_i[24] |=> ##1 state_q == ST_IDLE)
    else $error("immediate load took too long");
  c_add_done: cover property (@(posedge clk_i)
    state_q == ST_EXEC && op_e'(cmd_q.op) == alu_core_pkg::OP_ADD_A_M);
  c_indirect_read: cover property (@(posedge clk_i)
    state_q == ST_IDX && op_e'(cmd_q.op) == alu_core_pkg::OP_IDX_RD);
  c_pop: cover property (@(posedge clk_i)
    state_q == ST_WR2 && op_e'(cmd_q.op) == alu_core_pkg::OP_POPAF);

endmodule
`default_nettype wire

// ===== bench/far_side_model.sv
// Behavioural data memory, IO space and sixteen-bit timer beside the datapath.
`timescale 1ns/1ps
`default_nettype none
module far_side_model
(
  input  wire logic        clk_i,
  input  wire logic        mem_we_i,
  input  wire logic [7:0]  mem_addr_i,
  input  wire logic [7:0]  mem_wdata_i,
  input  wire logic        io_we_i,
  input  wire logic [7:0]  io_addr_i,
  input  wire logic [7:0]  io_wdata_i,
  input  wire logic        load_i,
  input  wire logic [15:0] value_i,
  output logic      [7:0]  mem_rdata_o,
  output logic      [7:0]  io_rdata_o,
  output logic      [15:0] count_o
);
  logic [7:0]  mem [256];
  logic [7:0]  io [256];
  logic [15:0] count = 16'h0000;
  assign mem_rdata_o = mem[mem_addr_i];
  assign io_rdata_o  = io[io_addr_i];
  assign count_o     = count;
  always @(posedge clk_i)
  begin
    if (mem_we_i)
      mem[mem_addr_i] <= mem_wdata_i;
    if (io_we_i)
      io[io_addr_i] <= io_wdata_i;
    if (load_i)
      count <= value_i;
  end
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking bench for the move, arithmetic and shift datapath.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_i = 1'h0;
  logic        rst_i = 1'h1;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic        we = 1'h0, cyc = 1'h0, stb = 1'h0, ack, mem_we, io_we, t_load;
  logic [7:0]  mem_addr, mem_wdata, io_addr, io_wdata, mem_rdata, io_rdata;
  logic [15:0] t_count, t_value;
  int          err_count = 0, comparisons = 0, cycles = 0;
  always #10 clk_i = ~clk_i;
  alu_move_shift_core i_alu_move_shift_core (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_we_i(we), .wb_sel_i(4'h1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_dat_o(rdat), .wb_ack_o(ack), .mem_rdata_i(mem_rdata), .io_rdata_i(io_rdata),
    .timer_count_i(t_count), .mem_we_o(mem_we), .mem_addr_o(mem_addr),
    .mem_wdata_o(mem_wdata), .io_we_o(io_we), .io_addr_o(io_addr), .io_wdata_o(io_wdata),
    .timer_load_o(t_load), .timer_value_o(t_value));
  far_side_model i_far_side_model (.clk_i(clk_i), .mem_we_i(mem_we), .mem_addr_i(mem_addr),
    .mem_wdata_i(mem_wdata), .io_we_i(io_we), .io_addr_i(io_addr), .io_wdata_i(io_wdata),
    .load_i(t_load), .value_i(t_value), .mem_rdata_o(mem_rdata), .io_rdata_o(io_rdata),
    .count_o(t_count));
  task print_verdict;
    $display("Counts: %0d errors in %0d comparisons", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'h1)
      @(posedge clk_i);
    r = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask
  task exec(input alu_core_pkg::op_e op, input logic [7:0] a, input logic [7:0] i,
            input logic b);
    wb(1'h1, alu_core_pkg::REG_CMD, {7'h00, b, i, a, 2'h0, op}, q);
    do
      wb(1'h0, alu_core_pkg::REG_STATUS, 32'h0, q);
    while (q[2:0] !== 3'h0);
  endtask
  task chk_reg(input logic [7:0] a, input logic [7:0] exp);
    wb(1'h0, a, 32'h0, q);
    chk({8'h00, q[7:0]}, {8'h00, exp});
  endtask
  task chk_wf(input logic [7:0] w, input logic [3:0] f);
    chk_reg(alu_core_pkg::REG_WORK, w);
    chk_reg(alu_core_pkg::REG_FLAGS, {4'h0, f});
  endtask
  task s_arith;
    chk_wf(8'h00, 4'h0);
    chk_reg(alu_core_pkg::REG_PTR, 8'h00);
    chk_reg(8'h14, 8'h00);
    exec(alu_core_pkg::OP_MOV_A_I, 8'h00, 8'h7F, 1'h0);
    exec(alu_core_pkg::OP_ADD_A_I, 8'h00, 8'h01, 1'h0);
    chk_wf(8'h80, 4'hC);
    exec(alu_core_pkg::OP_ADD_A_I, 8'h00, 8'h80, 1'h0);
    chk_wf(8'h00, 4'hB);
    exec(alu_core_pkg::OP_MOV_A_I, 8'h00, 8'h00, 1'h0);
    chk_wf(8'h00, 4'hB);
    exec(alu_core_pkg::OP_SUB_A_I, 8'h00, 8'h01, 1'h0);
    chk_wf(8'hFF, 4'h6);
  endtask
  task s_shift;
    alu_core_pkg::op_e ops [5] = '{alu_core_pkg::OP_SR_A, alu_core_pkg::OP_SRC_A,
      alu_core_pkg::OP_SL_A, alu_core_pkg::OP_SLC_A, alu_core_pkg::OP_SWAP_A};
    logic [7:0] w [5] = '{8'h40, 8'hA0, 8'h40, 8'h81, 8'h18};
    logic [3:0] f [5] = '{4'h6, 4'h4, 4'h6, 4'h4, 4'h4};
    exec(alu_core_pkg::OP_MOV_A_I, 8'h00, 8'h81, 1'h0);
    for (int k = 0; k < 5; k++)
    begin
      exec(ops[k], 8'h00, 8'h00, 1'h0);
      chk_wf(w[k], f[k]);
    end
  endtask
  task s_mem;
    i_far_side_model.io[5] <= 8'h00;
    i_far_side_model.mem[8'h20] <= 8'h33;
    i_far_side_model.mem[8'h21] <= 8'hFF;
    exec(alu_core_pkg::OP_MOV_A_IO, 8'h05, 8'h00, 1'h0);
    chk_wf(8'h00, 4'h5);
    exec(alu_core_pkg::OP_MOV_A_I, 8'h00, 8'h5A, 1'h0);
    exec(alu_core_pkg::OP_XCH, 8'h20, 8'h00, 1'h0);
    chk_wf(8'h33, 4'h5);
    chk({8'h00, i_far_side_model.mem[8'h20]}, 16'h005A);
    exec(alu_core_pkg::OP_CLEAR_M, 8'h20, 8'h00, 1'h0);
    chk({8'h00, i_far_side_model.mem[8'h20]}, 16'h0000);
    exec(alu_core_pkg::OP_INC_M, 8'h21, 8'h00, 1'h0);
    chk({8'h00, i_far_side_model.mem[8'h21]}, 16'h0000);
    chk_wf(8'h33, 4'h7);
  endtask
  task s_timer_stack;
    i_far_side_model.count <= 16'h1234;
    i_far_side_model.mem[8'h40] <= 8'hCD;
    i_far_side_model.mem[8'h41] <= 8'hAB;
    exec(alu_core_pkg::OP_TWL, 8'h30, 8'h00, 1'h0);
    chk({i_far_side_model.mem[8'h31], i_far_side_model.mem[8'h30]}, 16'h1234);
    exec(alu_core_pkg::OP_TWS, 8'h40, 8'h00, 1'h0);
    chk(t_count, 16'hABCD);
    wb(1'h1, alu_core_pkg::REG_PTR, 32'h50, q);
    exec(alu_core_pkg::OP_MOV_A_I, 8'h00, 8'hC3, 1'h0);
    exec(alu_core_pkg::OP_PUSHAF, 8'h00, 8'h00, 1'h0);
    chk({i_far_side_model.mem[8'h51][3:0], i_far_side_model.mem[8'h50]}, 12'h7C3);
    chk_reg(alu_core_pkg::REG_PTR, 8'h52);
    exec(alu_core_pkg::OP_ADD_A_I, 8'h00, 8'h01, 1'h0);
    exec(alu_core_pkg::OP_POPAF, 8'h00, 8'h00, 1'h0);
    chk_wf(8'hC3, 4'h7);
    chk_reg(alu_core_pkg::REG_PTR, 8'h50);
    i_far_side_model.mem[8'h60] <= 8'h70;
    i_far_side_model.mem[8'h61] <= 8'h00;
    i_far_side_model.mem[8'h70] <= 8'h9E;
    exec(alu_core_pkg::OP_IDX_RD, 8'h60, 8'h00, 1'h0);
    chk_wf(8'h9E, 4'h7);
    exec(alu_core_pkg::OP_CLEAR_M, 8'h40, 8'h00, 1'h1);
    chk({7'h00, q[16], i_far_side_model.mem[8'h40]}, 16'h01CD);
  endtask
  task s_mem_ops;
    alu_core_pkg::op_e ops [7] = '{alu_core_pkg::OP_ADDC_M_A, alu_core_pkg::OP_ADD_A_M,
      alu_core_pkg::OP_NADD_A_M, alu_core_pkg::OP_SUBC_M, alu_core_pkg::OP_DEC_M,
      alu_core_pkg::OP_SRC_M, alu_core_pkg::OP_SUBC_M_A};
    logic [7:0] w [7] = '{8'h9E, 8'hAF, 8'h62, 8'h62, 8'h62, 8'h62, 8'h62};
    logic [7:0] m [7] = '{8'h11, 8'h11, 8'h11, 8'h10, 8'h0F, 8'h07, 8'hA4};
    logic [3:0] f [7] = '{4'h6, 4'h0, 4'h6, 4'h0, 4'h4, 4'h6, 4'h2};
    i_far_side_model.mem[8'h22] <= 8'h72;
    for (int k = 0; k < 7; k++)
    begin
      exec(ops[k], 8'h22, 8'h00, 1'h0);
      chk_wf(w[k], f[k]);
      chk({8'h00, i_far_side_model.mem[8'h22]}, {8'h00, m[k]});
    end
    exec(alu_core_pkg::OP_MOV_IO_A, 8'h07, 8'h00, 1'h0);
    exec(alu_core_pkg::OP_IDX_WR, 8'h60, 8'h00, 1'h0);
    chk({i_far_side_model.io[7], i_far_side_model.mem[8'h70]}, 16'h6262);
    chk_wf(8'h62, 4'h2);
  endtask
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      err_count++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'h0;
    s_arith();
    s_shift();
    s_mem();
    s_timer_stack();
    s_mem_ops();
    print_verdict();
  end
endmodule
`default_nettype wire
